// ==== rtl/tfs_pkg.sv ====
/*
  Constants, types and byte-layout table for the track format sequencer.
  Assumes a single 20 MHz clock and a controller with an 8-port I/O window.
*/
package tfs_pkg;

  // ==========================================================================
  // Port window
  localparam logic [2:0] CMD_OFF      = 3'h0;
  localparam logic [2:0] DATA_OFF     = 3'h3;
  localparam logic [1:0] SERIAL_PAIR  = 2'h3;
  localparam logic [4:0] BASE_LOW     = 5'h00;

  // ==========================================================================
  // Layout figures
  localparam logic [7:0] SECTORS      = 8'h1A;
  localparam logic [7:0] FIRST_SECT   = 8'h01;
  localparam logic [7:0] TRACK_MAX    = 8'h4C;
  localparam logic [7:0] FILL_DEFAULT = 8'hE5;
  localparam logic [7:0] MARK_LO      = 8'hF5;
  localparam logic [7:0] MARK_HI      = 8'hFE;
  localparam logic [7:0] GAP_FM       = 8'hFF;
  localparam logic [7:0] GAP_MFM      = 8'h4E;
  localparam logic [7:0] IDX_MARK     = 8'hFC;
  localparam logic [7:0] SYNC_MFM     = 8'hF6;
  localparam logic [4:0] FM_FIRST     = 5'h03;
  localparam logic [4:0] FM_LAST      = 5'h10;
  localparam logic [4:0] MFM_FIRST    = 5'h04;
  localparam logic [4:0] MFM_LAST     = 5'h13;
  localparam int         FIFO_DEPTH   = 8;
  localparam int         BYTE_W       = 8;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CMD  = 3'b010,
    S_RUN  = 3'b100
  } tfs_state_t;

  typedef enum logic [2:0] {
    K_CONST = 3'h0,
    K_TRACK = 3'h1,
    K_SIDE  = 3'h2,
    K_SECT  = 3'h3,
    K_DATA  = 3'h4
  } tfs_kind_t;

  typedef struct packed {
    logic [8:0] len;
    tfs_kind_t  kind;
    logic [7:0] val;
  } tfs_seg_t;

  // ==========================================================================
  // Segment table, preamble then one sector record
  function automatic tfs_seg_t tfs_seg(input logic mfm, input logic [4:0] idx);
    tfs_seg_t s;
    s = '{9'h001, K_CONST, 8'hFF};
    if (!mfm) begin
      case (idx)
        5'h00:   s = '{9'h028, K_CONST, 8'hFF};
        5'h01:   s = '{9'h006, K_CONST, 8'h00};
        5'h02:   s = '{9'h001, K_CONST, 8'hFC};
        5'h03:   s = '{9'h01A, K_CONST, 8'hFF};
        5'h04:   s = '{9'h006, K_CONST, 8'h00};
        5'h05:   s = '{9'h001, K_CONST, 8'hFE};
        5'h06:   s = '{9'h001, K_TRACK, 8'h00};
        5'h07:   s = '{9'h001, K_SIDE,  8'h00};
        5'h08:   s = '{9'h001, K_SECT,  8'h00};
        5'h09:   s = '{9'h001, K_CONST, 8'h00};
        5'h0A:   s = '{9'h001, K_CONST, 8'hF7};
        5'h0B:   s = '{9'h00B, K_CONST, 8'hFF};
        5'h0C:   s = '{9'h006, K_CONST, 8'h00};
        5'h0D:   s = '{9'h001, K_CONST, 8'hFB};
        5'h0E:   s = '{9'h080, K_DATA,  8'h00};
        5'h0F:   s = '{9'h001, K_CONST, 8'hF7};
        default: s = '{9'h01B, K_CONST, 8'hFF};
      endcase
    end else begin
      case (idx)
        5'h00:   s = '{9'h050, K_CONST, 8'h4E};
        5'h01:   s = '{9'h00C, K_CONST, 8'h00};
        5'h02:   s = '{9'h003, K_CONST, 8'hF6};
        5'h03:   s = '{9'h001, K_CONST, 8'hFC};
        5'h04:   s = '{9'h032, K_CONST, 8'h4E};
        5'h05:   s = '{9'h00C, K_CONST, 8'h00};
        5'h06:   s = '{9'h003, K_CONST, 8'hF5};
        5'h07:   s = '{9'h001, K_CONST, 8'hFE};
        5'h08:   s = '{9'h001, K_TRACK, 8'h00};
        5'h09:   s = '{9'h001, K_SIDE,  8'h00};
        5'h0A:   s = '{9'h001, K_SECT,  8'h00};
        5'h0B:   s = '{9'h001, K_CONST, 8'h01};
        5'h0C:   s = '{9'h001, K_CONST, 8'hF7};
        5'h0D:   s = '{9'h016, K_CONST, 8'h4E};
        5'h0E:   s = '{9'h00C, K_CONST, 8'h00};
        5'h0F:   s = '{9'h003, K_CONST, 8'hF5};
        5'h10:   s = '{9'h001, K_CONST, 8'hFB};
        5'h11:   s = '{9'h100, K_DATA,  8'h00};
        5'h12:   s = '{9'h001, K_CONST, 8'hF7};
        default: s = '{9'h036, K_CONST, 8'h4E};
      endcase
    end
    return s;
  endfunction : tfs_seg

  function automatic logic tfs_is_mark(input logic [7:0] b);
    return (b >= MARK_LO) && (b <= MARK_HI);
  endfunction : tfs_is_mark

  // Returns {window hit, serial pair}
  function automatic logic [1:0] tfs_port_sel(input logic [7:0] addr,
                                              input logic [2:0] base);
    logic hit;
    hit = (addr[7:5] == base) && (addr[4:3] == 2'h0);
    return {hit, hit && (addr[2:1] == SERIAL_PAIR)};
  endfunction : tfs_port_sel

endpackage : tfs_pkg

// ==== rtl/tfs_stream_if.sv ====
/*
  Byte stream carrier between the sequencer's generator and its FIFO.
  Assumes both ends share one clock.
*/
interface tfs_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : tfs_stream_if

// ==== rtl/tfs_fifo.sv ====
/*
  Synchronous FIFO, valid/ready on both sides, with synchronous clear.
  Assumes DEPTH is a power of two.
*/
module tfs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  tfs_stream_if.snk         up,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================================
  // Pointers
  logic [AW:0]  wp_q;
  logic [AW:0]  wp_d;
  logic [AW:0]  rp_q;
  logic [AW:0]  rp_d;
  logic [W-1:0] mem_q [DEPTH];
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty     = (wp_q == rp_q);
  assign up.ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rp_q[AW-1:0]];
  assign push      = up.valid && !full;
  assign pop       = out_ready && !empty;

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (clr) begin
      wp_d = '0;
      rp_d = '0;
    end else begin
      if (push) begin
        wp_d = wp_q + 1'b1;
      end
      if (pop) begin
        rp_d = rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Storage needs no reset, empty flag hides it
  always_ff @(posedge clk) begin
    if (push && !clr) begin
      mem_q[wp_q[AW-1:0]] <= up.data;
    end
  end

endmodule : tfs_fifo

// ==== rtl/tfs_sequencer.sv ====
/*
  Track format byte sequencer: issues the track-write command, then answers
  each data request of the disk controller with the next layout byte.
  Assumes the controller's request and interrupt lines are synchronous to clk.
*/
module tfs_sequencer #(
  parameter logic [7:0] WT_CMD = 8'hF0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       mfm,
  input  wire logic [7:0] track,
  input  wire logic       side,
  input  wire logic [7:0] fill,
  input  wire logic [2:0] base_sel,
  input  wire logic       drq,
  input  wire logic       intrq,
  output logic [7:0]      io_addr,
  output logic [7:0]      io_dout,
  output logic            io_doe,
  output logic            io_wr,
  output logic            busy,
  output logic            done
);

  // ==========================================================================
  // Declarations
  tfs_pkg::tfs_state_t st_q;
  tfs_pkg::tfs_state_t st_d;
  logic                mfm_q;
  logic                mfm_d;
  logic [7:0]          track_q;
  logic [7:0]          track_d;
  logic                side_q;
  logic                side_d;
  logic [7:0]          fill_q;
  logic [7:0]          fill_d;
  logic [4:0]          seg_q;
  logic [4:0]          seg_d;
  logic [8:0]          cnt_q;
  logic [8:0]          cnt_d;
  logic [7:0]          sect_q;
  logic [7:0]          sect_d;
  logic                tail_q;
  logic                tail_d;
  logic                wait_q;
  logic                wait_d;
  logic                io_wr_q;
  logic                io_wr_d;
  logic [7:0]          io_addr_q;
  logic [7:0]          io_addr_d;
  logic [7:0]          io_dout_q;
  logic [7:0]          io_dout_d;
  logic                done_q;
  logic                done_d;
  tfs_pkg::tfs_seg_t   seg;
  logic [7:0]          gen_byte;
  logic                push;
  logic                send;
  logic [4:0]          first_idx;
  logic [4:0]          last_idx;
  logic [7:0]          data_addr;
  logic                q_valid;
  logic [7:0]          q_data;

  tfs_stream_if #(.W(tfs_pkg::BYTE_W)) gen_if ();

  // ==========================================================================
  // Byte generator
  assign seg       = tfs_pkg::tfs_seg(mfm_q, seg_q);
  assign first_idx = mfm_q ? tfs_pkg::MFM_FIRST : tfs_pkg::FM_FIRST;
  assign last_idx  = mfm_q ? tfs_pkg::MFM_LAST : tfs_pkg::FM_LAST;

  always_comb begin
    gen_byte = seg.val;
    if (tail_q) begin
      gen_byte = mfm_q ? tfs_pkg::GAP_MFM : tfs_pkg::GAP_FM;
    end else begin
      case (seg.kind)
        tfs_pkg::K_TRACK: gen_byte = track_q;
        tfs_pkg::K_SIDE:  gen_byte = {7'h00, side_q};
        tfs_pkg::K_SECT:  gen_byte = sect_q;
        tfs_pkg::K_DATA:  gen_byte = fill_q;
        default:          gen_byte = seg.val;
      endcase
    end
  end

  assign gen_if.valid = (st_q == tfs_pkg::S_RUN) && !intrq;
  assign gen_if.data  = gen_byte;
  assign push         = gen_if.valid && gen_if.ready;

  // ==========================================================================
  // Eight-word FIFO between generator and request servicing
  tfs_fifo #(
    .W     (tfs_pkg::BYTE_W),
    .DEPTH (tfs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .clr       (st_q != tfs_pkg::S_RUN),
    .up        (gen_if),
    .out_valid (q_valid),
    .out_ready (send),
    .out_data  (q_data)
  );

  // ==========================================================================
  // Port window
  // base on 32-port boundary
  assign data_addr = {base_sel, tfs_pkg::BASE_LOW} | {5'h00, tfs_pkg::DATA_OFF};
  // one write per request; wait for request to drop before the next
  assign send = (st_q == tfs_pkg::S_RUN) && drq && q_valid && !wait_q && !intrq
              && (tfs_pkg::tfs_port_sel(data_addr, base_sel) == 2'b10);

  // ==========================================================================
  // Control and sequencing
  always_comb begin
    st_d      = st_q;
    mfm_d     = mfm_q;
    track_d   = track_q;
    side_d    = side_q;
    fill_d    = fill_q;
    seg_d     = seg_q;
    cnt_d     = cnt_q;
    sect_d    = sect_q;
    tail_d    = tail_q;
    wait_d    = send || (wait_q && drq);
    io_wr_d   = send;
    io_addr_d = io_addr_q;
    io_dout_d = io_dout_q;
    done_d    = 1'b0;
    if (send) begin
      io_addr_d = data_addr;
      io_dout_d = q_data;
    end
    case (st_q)
      tfs_pkg::S_IDLE: begin
        wait_d = 1'b0;
        if (start) begin
          st_d    = tfs_pkg::S_CMD;
          mfm_d   = mfm;
          // track capped at the last cylinder
          track_d = (track > tfs_pkg::TRACK_MAX) ? tfs_pkg::TRACK_MAX : track;
          side_d  = side;
          // mark codes kept out of the data field
          fill_d  = tfs_pkg::tfs_is_mark(fill) ? tfs_pkg::FILL_DEFAULT : fill;
          seg_d   = 5'h00;
          cnt_d   = 9'h000;
          sect_d  = tfs_pkg::FIRST_SECT;
          tail_d  = 1'b0;
        end
      end
      tfs_pkg::S_CMD: begin
        io_wr_d   = 1'b1;
        io_addr_d = {base_sel, tfs_pkg::BASE_LOW} | {5'h00, tfs_pkg::CMD_OFF};
        io_dout_d = WT_CMD;
        st_d      = tfs_pkg::S_RUN;
      end
      tfs_pkg::S_RUN: begin
        if (intrq) begin
          st_d   = tfs_pkg::S_IDLE;
          done_d = 1'b1;
        end else if (push && !tail_q) begin
          if (cnt_q == 9'(seg.len - 9'h001)) begin
            cnt_d = 9'h000;
            if (seg_q == last_idx) begin
              if (sect_q == tfs_pkg::SECTORS) begin
                tail_d = 1'b1;
              end else begin
                sect_d = sect_q + 8'h01;
                seg_d  = first_idx;
              end
            end else begin
              seg_d = seg_q + 5'h01;
            end
          end else begin
            cnt_d = cnt_q + 9'h001;
          end
        end
      end
      default: begin
        st_d = tfs_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q      <= tfs_pkg::S_IDLE;
      mfm_q     <= 1'b0;
      track_q   <= 8'h00;
      side_q    <= 1'b0;
      fill_q    <= tfs_pkg::FILL_DEFAULT;
      seg_q     <= 5'h00;
      cnt_q     <= 9'h000;
      sect_q    <= tfs_pkg::FIRST_SECT;
      tail_q    <= 1'b0;
      wait_q    <= 1'b0;
      io_wr_q   <= 1'b0;
      io_addr_q <= 8'h00;
      io_dout_q <= 8'h00;
      done_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      mfm_q     <= mfm_d;
      track_q   <= track_d;
      side_q    <= side_d;
      fill_q    <= fill_d;
      seg_q     <= seg_d;
      cnt_q     <= cnt_d;
      sect_q    <= sect_d;
      tail_q    <= tail_d;
      wait_q    <= wait_d;
      io_wr_q   <= io_wr_d;
      io_addr_q <= io_addr_d;
      io_dout_q <= io_dout_d;
      done_q    <= done_d;
    end
  end

  assign io_wr   = io_wr_q;
  assign io_doe  = io_wr_q;
  assign io_addr = io_addr_q;
  assign io_dout = io_dout_q;
  assign busy    = (st_q != tfs_pkg::S_IDLE);
  assign done    = done_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic data_wr;
  assign data_wr = io_wr_q && (io_addr_q[2:0] == tfs_pkg::DATA_OFF);

  property p_wr_on_req;
    data_wr |-> $past(drq) && !$past(wait_q);
  endproperty
  a_wr_on_req: assert property (p_wr_on_req) else $error("write without request");
  // no write in the cycle right after a data write
  property p_one_per_req;
    data_wr |=> !io_wr_q;
  endproperty
  a_one_per_req: assert property (p_one_per_req) else $error("back to back write");
  property p_fm_pre;
    push && !mfm_q && !tail_q && (seg_q < tfs_pkg::FM_FIRST) |->
      gen_byte == ((seg_q == 5'h02) ? 8'hFC : (seg_q == 5'h01) ? 8'h00 : 8'hFF);
  endproperty
  a_fm_pre: assert property (p_fm_pre) else $error("bad FM preamble byte");
  property p_mfm_pre;
    push && mfm_q && (seg_q == 5'h02) |-> gen_byte == tfs_pkg::SYNC_MFM;
  endproperty
  a_mfm_pre: assert property (p_mfm_pre) else $error("bad MFM sync byte");
  property p_sect_range;
    (st_q == tfs_pkg::S_RUN) |-> (sect_q >= 8'h01) && (sect_q <= tfs_pkg::SECTORS);
  endproperty
  a_sect_range: assert property (p_sect_range) else $error("sector out of range");
  property p_sect_step;
    push && !tail_q && (seg_q == last_idx) && (cnt_q == 9'(seg.len - 9'h001))
      && (sect_q != tfs_pkg::SECTORS) && !intrq |=> sect_q == $past(sect_q) + 8'h01;
  endproperty
  a_sect_step: assert property (p_sect_step) else $error("sector did not step");
  property p_side;
    push && !tail_q && (seg.kind == tfs_pkg::K_SIDE) |-> gen_byte <= 8'h01;
  endproperty
  a_side: assert property (p_side) else $error("side byte not 0 or 1");
  property p_no_mark;
    push && !tail_q && (seg.kind != tfs_pkg::K_CONST) |-> !tfs_pkg::tfs_is_mark(gen_byte);
  endproperty
  a_no_mark: assert property (p_no_mark) else $error("mark code in field");
  property p_tail;
    push && tail_q |-> gen_byte == (mfm_q ? tfs_pkg::GAP_MFM : tfs_pkg::GAP_FM);
  endproperty
  a_tail: assert property (p_tail) else $error("bad tail filler");
  sequence s_irq;
    intrq && (st_q == tfs_pkg::S_RUN);
  endsequence
  sequence s_stopped;
    (st_q == tfs_pkg::S_IDLE) && done ##1 !io_wr_q && !busy;
  endsequence
  property p_stop;
    s_irq |=> s_stopped;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop on interrupt");
  // counters hold without an accepted byte
  property p_hold;
    (st_q == tfs_pkg::S_RUN) && !push |=> $stable(cnt_q) && $stable(seg_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without byte");
  property p_no_serial;
    io_wr_q |-> tfs_pkg::tfs_port_sel(io_addr_q, base_sel) == 2'b10;
  endproperty
  a_no_serial: assert property (p_no_serial) else $error("write hit serial port");
endmodule : tfs_sequencer

// ==== dv/tfs_ctl_model.sv ====
/*
  Behavioural disk controller model for the track format bench.
  Assumes one clock; it samples and drives at the falling edge.
*/
module tfs_ctl_model #(
  parameter int MAXB = 12000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  base_sel,
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_dout,
  input  wire logic        io_doe,
  input  wire logic        io_wr,
  input  wire logic [15:0] limit,
  input  wire logic [3:0]  gap,
  output logic             drq,
  output logic             intrq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:MAXB-1];
  logic [7:0] cmd;
  int         n;
  int         disk;
  int         bad;
  int         ncmd;
  int         wt;
  bit         act;

  // ==========================================================================
  // Port window and request engine
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      drq <= 1'b0;
      intrq <= 1'b0;
      act = 1'b0;
      wt = 0;
    end else begin
      intrq <= 1'b0;
      // Bus driven only while a write strobe stands
      if (io_doe !== io_wr) begin
        bad++;
      end
      if (io_wr === 1'b1) begin
        if (io_doe !== 1'b1 || io_addr[7:3] !== {base_sel, 2'b00}) begin
          bad++;
        end else if (io_addr[2:0] == 3'h0) begin
          act = 1'b1;
          n = 0;
          disk = 0;
          ncmd++;
          cmd = io_dout;
          wt = gap;
        end else if (io_addr[2:0] == 3'h3 && act) begin
          mem[n] = io_dout;
          n++;
          // F7 gives two CRC bytes, every other byte one
          disk += (io_dout == 8'hF7) ? 2 : 1;
          drq <= 1'b0;
          wt = gap;
          if (n == limit) begin
            act = 1'b0;
            intrq <= 1'b1;
          end
        end else begin
          bad++;
        end
      end else if (act && !drq) begin
        // one request per byte, slow or prompt
        if (wt == 0) begin
          drq <= 1'b1;
        end else begin
          wt--;
        end
      end
    end
  end
endmodule : tfs_ctl_model

// ==== dv/tfs_sequencer_bench.sv ====
/*
  Self-checking bench for the track format sequencer.
  Assumes the controller model in tfs_ctl_model and the tfs_pkg constants.
*/
module tfs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CMD = 8'hF0;
  logic        clk;
  logic        rst;
  logic        start;
  logic        mfm;
  logic        side;
  logic        drq;
  logic        intrq;
  logic        io_doe;
  logic        io_wr;
  logic        busy;
  logic        done;
  logic [7:0]  track;
  logic [7:0]  fill;
  logic [7:0]  io_addr;
  logic [7:0]  io_dout;
  logic [2:0]  base_sel;
  logic [15:0] limit;
  logic [3:0]  gap;
  logic [7:0]  exp_q [$];
  int          errors;
  int          comparisons;

  tfs_sequencer #(.WT_CMD(CMD)) i_tfs_sequencer (.clk(clk), .rst(rst), .start(start),
    .mfm(mfm), .track(track), .side(side), .fill(fill), .base_sel(base_sel), .drq(drq),
    .intrq(intrq), .io_addr(io_addr), .io_dout(io_dout), .io_doe(io_doe), .io_wr(io_wr),
    .busy(busy), .done(done));
  tfs_ctl_model i_tfs_ctl_model (.clk(clk), .rst(rst), .base_sel(base_sel),
    .io_addr(io_addr), .io_dout(io_dout), .io_doe(io_doe), .io_wr(io_wr), .limit(limit),
    .gap(gap), .drq(drq), .intrq(intrq));

  // ==========================================================================
  // Compare and report
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_cnt

  task automatic close_out;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Expected layout
  task automatic push(input int cnt, input logic [7:0] v);
    repeat (cnt) exp_q.push_back(v);
  endtask : push

  task automatic build(input logic m, input logic [7:0] t, input logic s, input logic [7:0] f);
    logic [7:0] g;
    logic [7:0] tc;
    logic [7:0] fc;
    g = m ? tfs_pkg::GAP_MFM : tfs_pkg::GAP_FM;
    tc = (t > tfs_pkg::TRACK_MAX) ? tfs_pkg::TRACK_MAX : t;
    fc = (f >= tfs_pkg::MARK_LO && f <= tfs_pkg::MARK_HI) ? tfs_pkg::FILL_DEFAULT : f;
    exp_q.delete();
    push(m ? 80 : 40, g);
    push(m ? 12 : 6, 8'h00);
    if (m) push(3, 8'hF6);
    push(1, 8'hFC);
    for (int k = 1; k <= 26; k++) begin
      push(m ? 50 : 26, g);
      push(m ? 12 : 6, 8'h00);
      if (m) push(3, 8'hF5);
      push(1, 8'hFE);
      push(1, tc);
      push(1, {7'h00, s});
      push(1, 8'(k));
      push(1, m ? 8'h01 : 8'h00);
      push(1, 8'hF7);
      push(m ? 22 : 11, g);
      push(m ? 12 : 6, 8'h00);
      if (m) push(3, 8'hF5);
      push(1, 8'hFB);
      push(m ? 256 : 128, fc);
      push(1, 8'hF7);
      push(m ? 54 : 27, g);
    end
    push(600, g);
  endtask : build

  // ==========================================================================
  // One format run, judged against the expected layout
  task automatic run_fmt(input logic m, input logic [7:0] t, input logic s,
                         input logic [7:0] f, input logic [2:0] b, input int lim,
                         input logic [3:0] gp, input bit poke);
    int c0;
    int f7;
    int k;
    build(m, t, s, f);
    c0 = i_tfs_ctl_model.ncmd;
    @(negedge clk);
    mfm = m;
    track = t;
    side = s;
    fill = f;
    base_sel = b;
    limit = lim[15:0];
    gap = gp;
    start = 1'b1;
    k = 0;
    while (done !== 1'b1) begin
      @(negedge clk);
      k++;
      // Stray start while busy, must be ignored
      start = (poke && k == 200) ? 1'b1 : 1'b0;
      if (k > 40000) begin
        errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, k, 40000);
        close_out();
      end
    end
    cmp_byte({7'h00, busy}, 8'h00);
    @(negedge clk);
    cmp_byte({7'h00, done}, 8'h00);
    repeat (20) @(negedge clk);
    cmp_cnt(i_tfs_ctl_model.n, lim);
    cmp_cnt(i_tfs_ctl_model.ncmd, c0 + 1);
    cmp_byte(i_tfs_ctl_model.cmd, CMD);
    cmp_cnt(i_tfs_ctl_model.bad, 0);
    f7 = 0;
    for (int i = 0; i < lim; i++) begin
      cmp_byte(i_tfs_ctl_model.mem[i], exp_q[i]);
      if (exp_q[i] == 8'hF7) f7++;
    end
    cmp_cnt(i_tfs_ctl_model.disk, lim + f7);
  endtask : run_fmt

  // ==========================================================================
  // Scenarios
  task automatic t_fm_full;
    run_fmt(1'b0, 8'h05, 1'b1, 8'hE5, 3'h1, 5806, 4'h0, 1'b0);
    $display("test fm_full ends, errors=%0d", errors);
  endtask : t_fm_full

  task automatic t_mfm_full;
    // Track above the cap and a mark-range fill byte
    run_fmt(1'b1, 8'h60, 1'b0, 8'hF9, 3'h7, 11614, 4'h0, 1'b0);
    $display("test mfm_full ends, errors=%0d", errors);
  endtask : t_mfm_full

  task automatic t_abort_slow;
    // Early interrupt with a slow controller and a stray start
    run_fmt(1'b0, 8'h4C, 1'b0, 8'h6D, 3'h3, 300, 4'h5, 1'b1);
    $display("test abort_slow ends, errors=%0d", errors);
  endtask : t_abort_slow

  // ==========================================================================
  // Clock, reset and sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    mfm = 1'b0;
    track = 8'h00;
    side = 1'b0;
    fill = 8'h00;
    base_sel = 3'h0;
    limit = 16'h0001;
    gap = 4'h0;
    errors = 0;
    comparisons = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    cmp_byte({io_wr, io_doe, busy, done, 4'h0}, 8'h00);
    cmp_byte(io_addr, 8'h00);
    cmp_byte(io_dout, 8'h00);
    t_fm_full();
    t_mfm_full();
    t_abort_slow();
    close_out();
  end
endmodule : tfs_sequencer_bench
